/* File: flash_cfg_bank.sv */
// segment, enhanced config and flag status registers behind the serial link
`include "flash_cfg_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module flash_cfg_bank (
  input  wire logic                     clk_sys,
  input  wire logic                     reset_n,
  input  wire logic                     link_sck,
  input  wire logic                     link_cs_n,
  input  wire logic [3:0]               link_dq_i,
  output logic      [3:0]               link_dq_o,
  output logic      [3:0]               link_dq_oe_n,
  input  wire logic                     busy_status_wr,
  input  wire logic                     busy_nvcfg_wr,
  input  wire logic                     busy_program,
  input  wire logic                     busy_erase,
  input  wire logic                     erase_suspended,
  input  wire logic                     program_suspended,
  input  wire logic                     erase_fail,
  input  wire logic                     erase_prot_refused,
  input  wire logic                     program_fail,
  input  wire logic                     program_prot_refused,
  input  wire logic                     program_zero_to_one,
  input  wire logic                     program_supply_high,
  input  wire logic                     data_mult64,
  input  wire logic                     supply_invalid,
  input  wire logic                     prot_sector_hit,
  input  wire logic                     otp_locked_hit,
  input  wire logic                     addr4_mode,
  input  wire logic [7:0]               nvcfg,
  input  wire logic [31:0]              pe_addr_in,
  input  wire logic                     pe_addr_load,
  output logic      [31:0]              pe_addr,
  input  wire logic [31:0]              rd_addr_in,
  input  wire logic                     rd_start,
  input  wire logic                     rd_next,
  output logic      [31:0]              rd_addr,
  output logic      [2:0]               seg_sel,
  output flash_cfg_pkg::lane_mode_t     lane_mode,
  output logic                          hold_reset_en,
  output logic                          accel_en,
  output logic      [2:0]               drive_code,
  output logic      [7:0]               flag_status
);
  import flash_cfg_pkg::*;

  // ==========================================================
  // shared decode
  // ==========================================================
  function automatic lane_mode_t lane_of(input logic [7:0] evc);
    if (!evc[`EVC_QUAD_BIT]) begin
      lane_of = LANE_QUAD;
    end else if (!evc[`EVC_DUAL_BIT]) begin
      lane_of = LANE_DUAL;
    end else begin
      lane_of = LANE_SINGLE;
    end
  endfunction

  function automatic logic [31:0] eff_addr(input logic [31:0] a,
                                           input logic        four,
                                           input logic [2:0]  seg);
    eff_addr = four ? a : {5'h00, seg, a[`SEG_LSB-1:0]};
  endfunction

  // ==========================================================
  // core registers
  // ==========================================================
  logic [7:0]  seg_q;
  logic [7:0]  evc_q;
  logic [7:0]  flag_q;
  logic [3:0]  err_q;
  logic        init_q;
  logic        cs_s1_q;
  logic        cs_s2_q;
  logic        wt_s1_q;
  logic        wt_s2_q;
  logic        wt_seen_q;
  logic        pend_q;
  logic [7:0]  pend_cmd_q;
  logic [7:0]  pend_data_q;
  // register image read by the link; it stops moving two core clocks after select falls
  logic [23:0] snap_q;
  logic [31:0] pe_addr_q;
  logic [31:0] rd_addr_q;

  // link side registers read by the core after their toggle settles
  logic        wr_tgl_q;
  logic [7:0]  wr_cmd_q;
  logic [7:0]  wr_data_q;

  // ==========================================================
  // write commit: applied once the frame has ended
  // ==========================================================
  wire        wr_new     = wt_s2_q != wt_seen_q;
  wire        commit     = pend_q & cs_s2_q & ~wr_new;
  wire        commit_evc = commit & (pend_cmd_q == `CMD_WR_EVC);
  wire        commit_seg = commit & (pend_cmd_q == `CMD_WR_SEG);
  wire        commit_clr = commit & (pend_cmd_q == `CMD_CLR_FLAG);
  wire [2:0]  drv_wr     = pend_data_q[2:0];
  wire        drv_rsvd   = (drv_wr == `DRV_RSVD_A) | (drv_wr == `DRV_RSVD_B);
  // mask taken as a full byte first, so only its upper five bits meet the data
  wire [7:0]  evc_msk    = `EVC_WR_MASK;
  wire [7:0]  evc_wr     = {pend_data_q[7:3] & evc_msk[7:3],
                            drv_rsvd ? evc_q[2:0] : drv_wr};
  wire [7:0]  evc_d      = commit_evc ? evc_wr : evc_q;
  wire [7:0]  seg_d      = commit_seg ? (pend_data_q & `SEG_WR_MASK) : seg_q;
  wire [2:0]  seg_init   = nvcfg[`NVC_SEG_BIT] ? `SEG_NV_SET : `SEG_NV_CLR;
  wire        pend_d     = wr_new | (pend_q & ~commit);

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cs_s1_q     <= 1'b1;
      cs_s2_q     <= 1'b1;
      wt_s1_q     <= 1'b0;
      wt_s2_q     <= 1'b0;
      wt_seen_q   <= 1'b0;
      pend_q      <= 1'b0;
      pend_cmd_q  <= 8'h00;
      pend_data_q <= 8'h00;
    end else begin
      cs_s1_q     <= link_cs_n;
      cs_s2_q     <= cs_s1_q;
      wt_s1_q     <= wr_tgl_q;
      wt_s2_q     <= wt_s1_q;
      wt_seen_q   <= wt_s2_q;
      pend_q      <= pend_d;
      if (wr_new) begin
        pend_cmd_q  <= wr_cmd_q;
        pend_data_q <= wr_data_q;
      end
    end
  end

  // the nonvolatile default is taken on the first edge after release
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      init_q <= 1'b0;
      seg_q  <= `SEG_RESET;
      evc_q  <= `EVC_RESET;
    end else begin
      init_q <= 1'b1;
      evc_q  <= evc_d;
      if (!init_q) begin
        seg_q <= {5'h00, seg_init};
      end else begin
        seg_q <= seg_d;
      end
    end
  end

  // ==========================================================
  // flag status
  // ==========================================================
  wire       busy_any  = busy_status_wr | busy_nvcfg_wr | busy_program | busy_erase;
  wire [3:0] err_set;
  assign err_set[3] = erase_fail | erase_prot_refused;
  assign err_set[2] = program_fail | program_prot_refused |
                      (program_zero_to_one & program_supply_high & data_mult64);
  assign err_set[1] = supply_invalid;
  assign err_set[0] = prot_sector_hit | otp_locked_hit;

  // a new error in the clearing cycle survives the clear
  wire [3:0] err_d  = err_set | (err_q & {4{~commit_clr}});
  wire [7:0] flag_d = {~busy_any,
                       erase_suspended,
                       err_d[3],
                       err_d[2],
                       err_d[1],
                       program_suspended,
                       err_d[0],
                       addr4_mode};

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      err_q  <= 4'h0;
      flag_q <= 8'h80;
    end else begin
      err_q  <= err_d;
      flag_q <= flag_d;
    end
  end

  // ==========================================================
  // address shaping
  // ==========================================================
  wire [24:0] rd_low_inc = rd_addr_q[`DIE_LSB-1:0] + 25'h0000001;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pe_addr_q <= 32'h00000000;
      rd_addr_q <= 32'h00000000;
    end else begin
      if (pe_addr_load) begin
        pe_addr_q <= eff_addr(pe_addr_in, addr4_mode, seg_q[2:0]);
      end
      if (rd_start) begin
        rd_addr_q <= eff_addr(rd_addr_in, addr4_mode, seg_q[2:0]);
      end else if (rd_next) begin
        // die bits are held, so a segment crossing leaves seg_q alone
        rd_addr_q <= {rd_addr_q[31:`DIE_LSB], rd_low_inc};
      end
    end
  end

  // ==========================================================
  // snapshot toward the link
  // ==========================================================
  // the link clock may stop between frames, so a toggle handshake clocked
  // by it would hand over a stale word at the start of the next frame.
  // instead the image refreshes every core clock while select is idle and
  // freezes two core clocks after select falls; it then stands still for
  // the whole frame and the link reads it as a quasi-static word.
  // limitation: the host must hold select low for at least three core
  // clocks before its first link edge, and a flag read shows the flags
  // as they were when the frame began.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      snap_q <= {`SEG_RESET, `EVC_RESET, 8'h80};
    end else if (cs_s2_q) begin
      snap_q <= {seg_q, evc_q, flag_q};
    end
  end

  assign pe_addr       = pe_addr_q;
  assign rd_addr       = rd_addr_q;
  assign seg_sel       = seg_q[2:0];
  assign lane_mode     = lane_of(evc_q);
  assign hold_reset_en = evc_q[`EVC_HOLD_BIT];
  assign accel_en      = ~evc_q[`EVC_ACCEL_BIT];
  assign drive_code    = evc_q[2:0];
  assign flag_status   = flag_q;

  // ==========================================================
  // link domain
  // ==========================================================
  // frame logic is cleared by chip select; a glitch on it aborts the frame
  wire         link_rst = link_cs_n | ~reset_n;
  // frozen by the core for the length of the frame, see the snapshot above
  wire  [23:0] word_l   = snap_q;
  link_phase_t phase_q;
  logic [3:0]  cnt_q;
  logic [7:0]  sh_q;
  logic [7:0]  cmd_q;
  logic [7:0]  tx_q;
  logic [3:0]  out_q;
  logic [3:0]  oe_n_q;

  // settings seen by the link are those committed before the frame began
  wire lane_mode_t lane_l = lane_of(word_l[15:8]);
  wire [3:0]   step     = (lane_l == LANE_QUAD) ? 4'h4 :
                          (lane_l == LANE_DUAL) ? 4'h2 : 4'h1;
  wire [3:0]   cnt_sum  = cnt_q + step;
  wire         byte_done = cnt_sum == 4'h8;
  wire [7:0]   sh_d     = (lane_l == LANE_QUAD) ? {sh_q[3:0], link_dq_i} :
                          (lane_l == LANE_DUAL) ? {sh_q[5:0], link_dq_i[1:0]} :
                                                  {sh_q[6:0], link_dq_i[0]};
  wire [7:0]   tx_rot   = (lane_l == LANE_QUAD) ? {tx_q[3:0], tx_q[7:4]} :
                          (lane_l == LANE_DUAL) ? {tx_q[5:0], tx_q[7:6]} :
                                                  {tx_q[6:0], tx_q[7]};
  wire         is_read  = (sh_d == `CMD_RD_EVC) | (sh_d == `CMD_RD_SEG) |
                          (sh_d == `CMD_RD_FLAG);
  wire         is_write = (sh_d == `CMD_WR_EVC) | (sh_d == `CMD_WR_SEG);
  wire [7:0]   rd_val   = (sh_d == `CMD_RD_SEG) ? word_l[23:16] :
                          (sh_d == `CMD_RD_EVC) ? word_l[15:8] : word_l[7:0];
  wire         fire_clr = (phase_q == PH_CMD) & byte_done & (sh_d == `CMD_CLR_FLAG);
  wire         fire_dat = (phase_q == PH_DATA) & byte_done;

  always_ff @(posedge link_sck or negedge reset_n) begin
    if (!reset_n) begin
      wr_tgl_q  <= 1'b0;
      wr_cmd_q  <= 8'h00;
      wr_data_q <= 8'h00;
    end else begin
      // command and data stand still once toggled; the core reads them
      // only after the toggle has passed its two-flop synchroniser
      if (fire_clr | fire_dat) begin
        wr_tgl_q  <= ~wr_tgl_q;
        wr_cmd_q  <= fire_clr ? sh_d : cmd_q;
        wr_data_q <= sh_d;
      end
    end
  end

  always_ff @(posedge link_sck or posedge link_rst) begin
    if (link_rst) begin
      phase_q <= PH_CMD;
      cnt_q   <= 4'h0;
      sh_q    <= 8'h00;
      cmd_q   <= 8'h00;
      tx_q    <= 8'h00;
    end else begin
      sh_q  <= sh_d;
      cnt_q <= byte_done ? 4'h0 : cnt_sum;
      case (phase_q)
        PH_CMD: begin
          if (byte_done) begin
            cmd_q <= sh_d;
            if (is_read) begin
              tx_q    <= rd_val;
              phase_q <= PH_READ;
            end else if (is_write) begin
              phase_q <= PH_DATA;
            end else begin
              phase_q <= PH_DONE;
            end
          end
        end
        PH_DATA: begin
          if (byte_done) begin
            phase_q <= PH_DONE;
          end
        end
        PH_READ: begin
          // the register value repeats for as long as the host clocks
          tx_q <= tx_rot;
        end
        default: begin
          phase_q <= PH_DONE;
        end
      endcase
    end
  end

  // launch on the falling edge so the host samples on the next rise
  always_ff @(negedge link_sck or posedge link_rst) begin
    if (link_rst) begin
      out_q  <= 4'h0;
      oe_n_q <= 4'hf;
    end else if (phase_q == PH_READ) begin
      case (lane_l)
        LANE_QUAD: begin
          out_q  <= tx_q[7:4];
          oe_n_q <= 4'h0;
        end
        LANE_DUAL: begin
          out_q  <= {2'b00, tx_q[7:6]};
          oe_n_q <= 4'hc;
        end
        default: begin
          out_q  <= {2'b00, tx_q[7], 1'b0};
          oe_n_q <= 4'hd;
        end
      endcase
    end else begin
      out_q  <= 4'h0;
      oe_n_q <= 4'hf;
    end
  end

  assign link_dq_o    = out_q;
  assign link_dq_oe_n = oe_n_q;

endmodule // flash_cfg_bank
`default_nettype wire

/* File: flash_cfg_regs.svh */
// command codes, field positions and reset values of the segment and config registers, and the flag register bit positions
`ifndef FLASH_CFG_REGS_SVH
`define FLASH_CFG_REGS_SVH

`define CMD_RD_EVC      8'h65
`define CMD_WR_EVC      8'h61
`define CMD_RD_SEG      8'hc8
`define CMD_WR_SEG      8'hc5
`define CMD_RD_FLAG     8'h70
`define CMD_CLR_FLAG    8'h50

`define EVC_RESET       8'hdf
`define EVC_WR_MASK     8'hdf
`define SEG_RESET       8'h00
`define SEG_WR_MASK     8'h07
`define SEG_NV_SET      3'h0
`define SEG_NV_CLR      3'h7
`define NVC_SEG_BIT     1

`define EVC_QUAD_BIT    7
`define EVC_DUAL_BIT    6
`define EVC_HOLD_BIT    4
`define EVC_ACCEL_BIT   3
`define DRV_RSVD_A      3'h0
`define DRV_RSVD_B      3'h4

`define FLG_READY       7
`define FLG_ERS_SUSP    6
`define FLG_ERS_ERR     5
`define FLG_PRG_ERR     4
`define FLG_SUPPLY_ERR  3
`define FLG_PRG_SUSP    2
`define FLG_PROT_ERR    1
`define FLG_ADDR4       0

`define SEG_LSB         24
`define DIE_LSB         25

`endif

/* File: flash_cfg_pkg.sv */
// types shared by the register bank
`default_nettype none
package flash_cfg_pkg;

  typedef enum logic [1:0] {
    LANE_SINGLE = 2'b00,
    LANE_DUAL   = 2'b01,
    LANE_QUAD   = 2'b10
  } lane_mode_t;

  // gray along cmd -> data and cmd -> done only; data -> done and cmd -> read change both bits
  typedef enum logic [1:0] {
    PH_CMD  = 2'b00,
    PH_DATA = 2'b01,
    PH_READ = 2'b11,
    PH_DONE = 2'b10
  } link_phase_t;

endpackage
`default_nettype wire

/* File: flash_cfg_bank_monitor.sv */
// checker for the segment, config and flag register bank
`timescale 1ns/100ps
`default_nettype none
module flash_cfg_bank_monitor (
  input wire logic        clk_sys,
  input wire logic        reset_n,
  input wire logic        link_cs_n,
  input wire logic        busy_status_wr,
  input wire logic        busy_nvcfg_wr,
  input wire logic        busy_program,
  input wire logic        busy_erase,
  input wire logic        erase_suspended,
  input wire logic        program_suspended,
  input wire logic        erase_fail,
  input wire logic        program_zero_to_one,
  input wire logic        program_supply_high,
  input wire logic        data_mult64,
  input wire logic        supply_invalid,
  input wire logic        prot_sector_hit,
  input wire logic        otp_locked_hit,
  input wire logic        addr4_mode,
  input wire logic [31:0] pe_addr_in,
  input wire logic        pe_addr_load,
  input wire logic [31:0] pe_addr,
  input wire logic [31:0] rd_addr_in,
  input wire logic        rd_start,
  input wire logic        rd_next,
  input wire logic [31:0] rd_addr,
  input wire logic [2:0]  seg_sel,
  input wire logic [2:0]  drive_code,
  input wire logic [7:0]  flag_status
);
  // ==========================================
  // helpers
  wire busy_any = busy_status_wr | busy_nvcfg_wr | busy_program | busy_erase;
  wire [23:0] pe_low = pe_addr_in[23:0];
  wire [23:0] rs_low = rd_addr_in[23:0];
  wire [6:0]  rd_hi  = rd_addr[31:25];
  wire [24:0] rd_lo  = rd_addr[24:0];
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // ==========================================
  // assertions
  a_ready_bit: assert property (1'b1 |=> flag_status[7] == !$past(busy_any))
    else $error("ready bit does not follow busy inputs");
  a_suspend_bits: assert property (1'b1 |=> flag_status[6] == $past(erase_suspended)
    && flag_status[2] == $past(program_suspended)) else $error("suspend bits wrong");
  a_addr_mode_bit: assert property (1'b1 |=> flag_status[0] == $past(addr4_mode))
    else $error("addressing bit wrong");
  a_erase_err: assert property (erase_fail |=> flag_status[5])
    else $error("erase error not recorded");
  a_program_combo: assert property (program_zero_to_one && program_supply_high && data_mult64
    |=> flag_status[4]) else $error("program error not recorded");
  a_supply_err: assert property (supply_invalid |=> flag_status[3])
    else $error("supply error not recorded");
  a_prot_sticky: assert property ($fell(flag_status[1]) |-> link_cs_n
    && !$past(prot_sector_hit || otp_locked_hit)) else $error("protection bit lost");
  a_pe_three: assert property (pe_addr_load && !addr4_mode |=>
    pe_addr == {5'h00, $past(seg_sel), $past(pe_low)}) else $error("segment address wrong");
  a_pe_four: assert property (pe_addr_load && addr4_mode |=> pe_addr == $past(pe_addr_in))
    else $error("four byte address altered");
  a_rd_begin: assert property (rd_start && !addr4_mode |=>
    rd_addr == {5'h00, $past(seg_sel), $past(rs_low)}) else $error("read start wrong");
  a_rd_wrap: assert property (rd_next && !rd_start |=>
    rd_addr == {$past(rd_hi), 25'($past(rd_lo) + 25'h1)}) else $error("read pointer wrong");
  a_drive_legal: assert property (1'b1 |-> drive_code != 3'h0 && drive_code != 3'h4)
    else $error("reserved drive code stored");
endmodule // flash_cfg_bank_monitor
`default_nettype wire

/* File: link_host.sv */
// serial host model issuing register frames on the link
`timescale 1ns/100ps
`default_nettype none
module link_host (
  output logic            link_sck,
  output logic            link_cs_n,
  output logic [3:0]      link_dq_i,
  input  wire logic [3:0] link_dq_o
);
  // ==========================================
  // frame tasks, 30 ns link clock, stopped between frames
  initial begin
    link_sck = 1'b0;
    link_cs_n = 1'b1;
    link_dq_i = 4'h0;
  end
  task automatic put(input logic [7:0] b, input int w);
    for (int i = 8 - w; i >= 0; i -= w) begin
      link_dq_i = 4'(b >> i) & 4'((1 << w) - 1);
      #15 link_sck = 1'b1;
      #15 link_sck = 1'b0;
    end
  endtask
  task automatic get(output logic [7:0] b, input int w);
    b = 8'h00;
    for (int i = 0; i < 8; i += w) begin
      #15 link_sck = 1'b1;
      b = (b << w) | ((w == 1) ? {7'h00, link_dq_o[1]} : {4'h0, link_dq_o & 4'((1 << w) - 1)});
      #15 link_sck = 1'b0;
    end
  endtask
  // mode 0 command only, 1 write a byte, 2 read a byte; one command a frame
  task automatic frame(input logic [7:0] cmd, input logic [7:0] wd, input int w, input int mode,
                       output logic [7:0] rd);
    rd = 8'h00;
    link_cs_n = 1'b0;
    // select leads the first edge by more than three core clocks
    #45;
    put(cmd, w);
    if (mode == 1) put(wd, w);
    if (mode == 2) get(rd, w);
    #15 link_cs_n = 1'b1;
    // released lines must not keep showing the last bits
    link_dq_i = ~link_dq_i;
    #150;
  endtask
endmodule // link_host
`default_nettype wire

/* File: tb.sv */
// testbench for the segment, config and flag register bank
`timescale 1ns/100ps
`default_nettype none
module tb;
  import flash_cfg_pkg::*;
  logic clk_sys, reset_n, pe_addr_load, rd_start, rd_next, addr4_mode, hold_reset_en, accel_en;
  logic link_sck, link_cs_n, erase_suspended, program_suspended;
  logic [3:0]  link_dq_i, link_dq_o, link_dq_oe_n, busy_v;
  logic [6:0]  ev;
  logic [2:0]  cv, seg_sel, drive_code;
  logic [7:0]  nvcfg, flag_status, v;
  logic [31:0] pe_addr_in, pe_addr, rd_addr_in, rd_addr;
  lane_mode_t  lane_mode;
  int          n_fail, comparisons;
  flash_cfg_bank flash_cfg_bank_inst (.clk_sys(clk_sys), .reset_n(reset_n), .link_sck(link_sck),
    .link_cs_n(link_cs_n), .link_dq_i(link_dq_i), .link_dq_o(link_dq_o),
    .link_dq_oe_n(link_dq_oe_n), .busy_status_wr(busy_v[0]), .busy_nvcfg_wr(busy_v[1]),
    .busy_program(busy_v[2]), .busy_erase(busy_v[3]), .erase_suspended(erase_suspended),
    .program_suspended(program_suspended), .erase_fail(ev[0]), .erase_prot_refused(ev[1]),
    .program_fail(ev[2]), .program_prot_refused(ev[3]), .supply_invalid(ev[4]),
    .prot_sector_hit(ev[5]), .otp_locked_hit(ev[6]), .program_zero_to_one(cv[0]),
    .program_supply_high(cv[1]), .data_mult64(cv[2]), .addr4_mode(addr4_mode), .nvcfg(nvcfg),
    .pe_addr_in(pe_addr_in), .pe_addr_load(pe_addr_load), .pe_addr(pe_addr),
    .rd_addr_in(rd_addr_in), .rd_start(rd_start), .rd_next(rd_next), .rd_addr(rd_addr),
    .seg_sel(seg_sel), .lane_mode(lane_mode), .hold_reset_en(hold_reset_en),
    .accel_en(accel_en), .drive_code(drive_code), .flag_status(flag_status));
  link_host link_host_inst (.link_sck(link_sck), .link_cs_n(link_cs_n), .link_dq_i(link_dq_i),
    .link_dq_o(link_dq_o));
  // ==========================================
  // helpers
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic final_report;
    if (n_fail == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ==========================================
  // scenarios
  task automatic t_defaults;
    chk("flag", 32'h80, 32'(flag_status));
    chk("seg", 32'h0, 32'(seg_sel));
    link_host_inst.frame(8'h65, 8'h00, 1, 2, v);
    chk("cfg read", 32'hdf, 32'(v));
    link_host_inst.frame(8'hc8, 8'h00, 1, 2, v);
    chk("seg read", 32'h0, 32'(v));
  endtask
  task automatic t_segment;
    link_host_inst.frame(8'hc5, 8'hfd, 1, 1, v);
    link_host_inst.frame(8'hc8, 8'h00, 1, 2, v);
    chk("seg read", 32'h05, 32'(v));
    chk("seg", 32'h5, 32'(seg_sel));
    for (int m = 0; m < 2; m++) begin
      @(posedge clk_sys);
      addr4_mode <= m[0];
      pe_addr_in <= 32'hffabcdef;
      pe_addr_load <= 1'b1;
      @(posedge clk_sys);
      pe_addr_load <= 1'b0;
      @(negedge clk_sys);
      chk("pe addr", m ? 32'hffabcdef : 32'h05abcdef, pe_addr);
    end
    @(posedge clk_sys);
    addr4_mode <= 1'b0;
    rd_addr_in <= 32'h00ffffff;
    rd_start <= 1'b1;
    @(posedge clk_sys);
    rd_start <= 1'b0;
    rd_next <= 1'b1;
    @(posedge clk_sys);
    rd_next <= 1'b0;
    @(negedge clk_sys);
    chk("rd wrap", 32'h04000000, rd_addr);
    chk("seg kept", 32'h5, 32'(seg_sel));
  endtask
  task automatic t_config;
    logic [7:0] wv [4] = '{8'h00, 8'h9a, 8'hfc, 8'hdf};
    logic [7:0] rv [4] = '{8'h07, 8'h9a, 8'hda, 8'hdf};
    int lw [4] = '{4, 2, 1, 1};
    int w;
    w = 1;
    for (int i = 0; i < 4; i++) begin
      link_host_inst.frame(8'h61, wv[i], w, 1, v);
      w = lw[i];
      cyc(5);
      chk("lane", (w == 4) ? 32'(LANE_QUAD) : (w == 2) ? 32'(LANE_DUAL) : 32'(LANE_SINGLE),
          32'(lane_mode));
      chk("hold", 32'(rv[i][4]), 32'(hold_reset_en));
      chk("accel", 32'(!rv[i][3]), 32'(accel_en));
      chk("drive", 32'(rv[i][2:0]), 32'(drive_code));
      link_host_inst.frame(8'h65, 8'h00, w, 2, v);
      chk("cfg read", 32'(rv[i]), 32'(v));
    end
  endtask
  task automatic t_flags;
    logic [7:0] eb [7] = '{8'h20, 8'h20, 8'h10, 8'h10, 8'h08, 8'h02, 8'h02};
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys);
      busy_v <= 4'(1 << i);
      cyc(2);
      chk("busy", 32'h00, 32'(flag_status));
    end
    busy_v <= 4'h0;
    erase_suspended <= 1'b1;
    program_suspended <= 1'b1;
    addr4_mode <= 1'b1;
    cyc(20);
    link_host_inst.frame(8'h70, 8'h00, 1, 2, v);
    chk("flag read", 32'hc5, 32'(v));
    @(posedge clk_sys);
    erase_suspended <= 1'b0;
    program_suspended <= 1'b0;
    addr4_mode <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_sys);
      if (i < 7) ev <= 7'(1 << i);
      else cv <= 3'h7;
      @(posedge clk_sys);
      ev <= 7'h00;
      cv <= 3'h0;
      cyc(4);
      chk("sticky", (i < 7) ? 32'(8'h80 | eb[i]) : 32'h90, 32'(flag_status));
      link_host_inst.frame(8'h50, 8'h00, 1, 0, v);
      chk("cleared", 32'h80, 32'(flag_status));
    end
    @(posedge clk_sys);
    cv <= 3'h3;
    @(posedge clk_sys);
    cv <= 3'h0;
    cyc(3);
    chk("partial combo", 32'h80, 32'(flag_status));
  endtask
  task automatic t_nv_default;
    @(posedge clk_sys);
    nvcfg <= 8'h00;
    reset_n <= 1'b0;
    cyc(3);
    reset_n <= 1'b1;
    cyc(3);
    chk("seg nv", 32'h7, 32'(seg_sel));
  endtask
  initial begin
    {reset_n, pe_addr_load, rd_start, rd_next, addr4_mode, erase_suspended} = 6'h00;
    {program_suspended, busy_v, ev, cv} = 15'h0000;
    {pe_addr_in, rd_addr_in} = 64'h0;
    nvcfg = 8'h02;
    n_fail = 0;
    comparisons = 0;
    cyc(12);
    reset_n <= 1'b1;
    cyc(20);
    t_defaults();
    t_segment();
    t_config();
    t_flags();
    t_nv_default();
    final_report();
  end
  initial begin
    #100000;
    n_fail++;
    final_report();
  end
endmodule // tb
bind flash_cfg_bank flash_cfg_bank_monitor flash_cfg_bank_monitor_inst (.clk_sys(clk_sys),
  .reset_n(reset_n), .link_cs_n(link_cs_n), .busy_status_wr(busy_status_wr),
  .busy_nvcfg_wr(busy_nvcfg_wr), .busy_program(busy_program), .busy_erase(busy_erase),
  .erase_suspended(erase_suspended), .program_suspended(program_suspended),
  .erase_fail(erase_fail), .program_zero_to_one(program_zero_to_one),
  .program_supply_high(program_supply_high), .data_mult64(data_mult64),
  .supply_invalid(supply_invalid), .prot_sector_hit(prot_sector_hit),
  .otp_locked_hit(otp_locked_hit), .addr4_mode(addr4_mode), .pe_addr_in(pe_addr_in),
  .pe_addr_load(pe_addr_load), .pe_addr(pe_addr), .rd_addr_in(rd_addr_in), .rd_start(rd_start),
  .rd_next(rd_next), .rd_addr(rd_addr), .seg_sel(seg_sel), .drive_code(drive_code),
  .flag_status(flag_status));
`default_nettype wire
